// file: design/tcs_clock_sync.sv
// Added by the designer: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module tcs_clock_sync (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic frame_valid,
  input wire logic frame_sync,
  input wire logic frame_startup,
  input wire logic [tcs_pkg::ID_W-1:0] frame_id,
  input wire logic [tcs_pkg::DEV_W-1:0] frame_dev,
  input wire logic strp_at_ap,
  input wire logic cycle_end,
  input wire logic cycle_odd,
  input wire logic integrating,
  input wire logic dyn_slot_max,
  input wire logic wus_a,
  input wire logic wus_b,
  input wire logic idle_a,
  input wire logic idle_b,
  output logic [1:0] poc_state,
  output logic [tcs_pkg::RC_W-1:0] rate_corr,
  output logic [tcs_pkg::DEV_W-1:0] offset_corr,
  output logic [tcs_pkg::NODE_W-1:0] startup_nodes
);
  import tcs_pkg::*;
  logic [31:0] ctrl_ff;
  logic mrc_ff;
  logic ccf_ff;
  logic sfo_ff;
  logic [1:0] wup_ff;
  tcs_poc_t poc_ff;
  logic [RC_W-1:0] rate_ff;
  logic [DEV_W-1:0] off_ff;
  logic [NODE_W-1:0] su_ff;
  logic [NODE_W-1:0] distinct_ff;
  logic [1:0] init_wait_ff;
  logic init_done_ff;
  logic [DEV_W-1:0] dev_held_ff;
  logic dev_held_vld_ff;
  logic pair_ff;
  logic signed [DEV_W+4:0] pair_sum_ff;
  logic [NODE_W-1:0] pair_cnt_ff;
  logic ack_ff;
  logic [31:0] rdata_ff;
  logic [1:0] wup_pulse;
  logic even_store;
  logic odd_hit;
  logic [DEV_W-1:0] odd_hit_dev;
  logic [NODE_W-1:0] even_cnt;
  logic [NODE_W-1:0] max_node;
  logic allow_halt;
  logic [7:0] init_off;
  logic [DEV_W-1:0] dev_use;
  logic sync_rx;
  logic odd_use;
  logic odd_end;
  logic missing_term;
  logic overflow_evt;
  logic wr_sel;
  logic rd_sel;
  logic [31:0] status_word;
  logic clr_mrc;
  logic clr_ccf;
  logic clr_sfo;
  logic [1:0] clr_wup;
  assign max_node = ctrl_ff[CTRL_MAXNODE_LSB +: NODE_W];
  assign allow_halt = ctrl_ff[CTRL_HALT_BIT];
  assign init_off = ctrl_ff[CTRL_INITOFF_LSB +: 8];
  assign wr_sel = avs_write && !ack_ff;
  assign rd_sel = avs_read && !ack_ff;
  assign clr_mrc = wr_sel && (avs_address == ADDR_STATUS[4:0]) && avs_byteenable[0]
                   && avs_writedata[ST_MRC];
  assign clr_ccf = wr_sel && (avs_address == ADDR_STATUS[4:0]) && avs_byteenable[0]
                   && avs_writedata[ST_CCF];
  assign clr_sfo = wr_sel && (avs_address == ADDR_STATUS[4:0]) && avs_byteenable[0]
                   && avs_writedata[ST_SFO];
  assign clr_wup[0] = wr_sel && (avs_address == ADDR_STATUS[4:0]) && avs_byteenable[0]
                      && avs_writedata[ST_WUPA];
  assign clr_wup[1] = wr_sel && (avs_address == ADDR_STATUS[4:0]) && avs_byteenable[0]
                      && avs_writedata[ST_WUPB];
  tcs_wakeup_det u_wu_a (
    .sys_clk(sys_clk),
    .rst(rst),
    .clk_en(clk_en),
    .wus_pulse(wus_a),
    .idle_ok(idle_a),
    .pattern_pulse(wup_pulse[0])
  );
  tcs_wakeup_det u_wu_b (
    .sys_clk(sys_clk),
    .rst(rst),
    .clk_en(clk_en),
    .wus_pulse(wus_b),
    .idle_ok(idle_b),
    .pattern_pulse(wup_pulse[1])
  );
  // sync frame acceptance, decided on frame_valid and frame_sync so a trailing frame cannot mask it
  assign sync_rx = frame_valid && frame_sync;
  // distinct frames limited per double cycle
  assign even_store = sync_rx && !cycle_odd && (even_cnt < max_node);
  assign dev_use = frame_dev;
  tcs_sync_table u_even (
    .sys_clk(sys_clk),
    .rst(rst),
    .clk_en(clk_en),
    .clear(cycle_end && cycle_odd),
    .store(even_store),
    .id_in(frame_id),
    .dev_in(dev_use),
    .hit(odd_hit),
    .hit_dev(odd_hit_dev),
    .count(even_cnt)
  );
  // odd frame matching even entry forms a pair
  assign odd_use = sync_rx && cycle_odd && odd_hit;
  assign odd_end = cycle_end && cycle_odd;
  // no usable pair at the end of the double cycle
  assign missing_term = odd_end && (pair_cnt_ff == '0) && !odd_use;
  // only too many sync frames; dyn_slot_max ignored here
  assign overflow_evt = sync_rx && ((!cycle_odd && (even_cnt >= max_node))
                        || (cycle_odd && !odd_hit && (distinct_ff >= max_node)));
  // distinct sync frames counted: even-cycle stores and unmatched odd-cycle frames, held to odd cycle end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      distinct_ff <= '0;
    end else if (clk_en) begin
      if (odd_end) begin
        distinct_ff <= '0;
      end else if (even_store) begin
        distinct_ff <= distinct_ff + 1'b1;
      end else if (sync_rx && cycle_odd && !odd_hit && (distinct_ff < max_node)) begin
        distinct_ff <= distinct_ff + 1'b1;
      end
    end
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pair_cnt_ff <= '0;
      pair_sum_ff <= '0;
      pair_ff <= 1'b0;
    end else if (clk_en) begin
      pair_ff <= odd_use;
      if (odd_end) begin
        pair_cnt_ff <= '0;
        pair_sum_ff <= '0;
      end else if (odd_use) begin
        pair_cnt_ff <= pair_cnt_ff + 1'b1;
        pair_sum_ff <= pair_sum_ff + (DEV_W+5)'($signed(dev_use))
                       - (DEV_W+5)'($signed(odd_hit_dev));
      end
    end
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      dev_held_ff <= '0;
      dev_held_vld_ff <= 1'b0;
    end else if (clk_en) begin
      if (sync_rx && !cycle_odd) begin
        dev_held_ff <= dev_use;
        dev_held_vld_ff <= 1'b1;
      end else if (odd_end) begin
        dev_held_vld_ff <= 1'b0;
      end
    end
  end
  // start-up frames only while below max-node
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      su_ff <= '0;
    end else if (clk_en) begin
      if (odd_end) begin
        su_ff <= '0;
      end else if (even_store && frame_startup) begin
        su_ff <= su_ff + 1'b1;
      end
    end
  end
  // rate and offset correction; initial value from initial offset
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rate_ff <= '0;
      off_ff <= '0;
      init_wait_ff <= '0;
      init_done_ff <= 1'b0;
    end else if (clk_en) begin
      if (integrating && !init_done_ff) begin
        rate_ff <= RC_W'(init_off);
        init_done_ff <= 1'b1;
        init_wait_ff <= 2'(INIT_RATE_DELAY_CYCLES);
      end else if (!integrating) begin
        init_done_ff <= 1'b0;
      end
      if (cycle_end && (init_wait_ff != '0)) begin
        init_wait_ff <= init_wait_ff - 1'b1;
      end
      if (!cycle_odd && dev_held_vld_ff && cycle_end) begin
        off_ff <= dev_held_ff;
      end
      // missing term keeps the last rate value
      if (odd_end && (pair_cnt_ff != '0) && (init_wait_ff == '0)) begin
        rate_ff <= RC_W'(pair_sum_ff);
      end
    end
  end
  // missing term drives the protocol state
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      poc_ff <= TCS_POC_STARTUP;
    end else if (clk_en) begin
      case (poc_ff)
        TCS_POC_STARTUP: begin
          if (missing_term) begin
            poc_ff <= TCS_POC_STARTUP;
          end else if (odd_end && !integrating) begin
            poc_ff <= TCS_POC_NORMAL_ACTIVE;
          end
        end
        TCS_POC_NORMAL_ACTIVE: begin
          if (missing_term) begin
            poc_ff <= allow_halt ? TCS_POC_HALT : TCS_POC_NORMAL_PASSIVE;
          end
        end
        TCS_POC_NORMAL_PASSIVE: begin
          if (missing_term && allow_halt) begin
            poc_ff <= TCS_POC_HALT;
          end else if (odd_end && (pair_cnt_ff != '0)) begin
            poc_ff <= TCS_POC_NORMAL_ACTIVE;
          end
        end
        TCS_POC_HALT: begin
          poc_ff <= TCS_POC_HALT;
        end
        default: begin
          poc_ff <= TCS_POC_STARTUP;
        end
      endcase
    end
  end
  // sticky flags, set wins over clear
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mrc_ff <= 1'b0;
      ccf_ff <= 1'b0;
    end else if (clk_en) begin
      mrc_ff <= missing_term || (mrc_ff && !clr_mrc);
      ccf_ff <= missing_term || (ccf_ff && !clr_ccf);
    end
  end
  // overflow flag has no path to poc_ff
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sfo_ff <= 1'b0;
    end else if (clk_en) begin
      sfo_ff <= overflow_evt || (sfo_ff && !clr_sfo);
    end
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wup_ff <= '0;
    end else if (clk_en) begin
      wup_ff <= wup_pulse | (wup_ff & ~clr_wup);
    end
  end
  always_comb begin
    status_word = '0;
    status_word[ST_MRC] = mrc_ff;
    status_word[ST_CCF] = ccf_ff;
    status_word[ST_SFO] = sfo_ff;
    status_word[ST_WUPA] = wup_ff[0];
    status_word[ST_WUPB] = wup_ff[1];
    status_word[ST_POC_LSB +: 2] = poc_ff;
  end
  // one wait cycle per access keeps read data registered
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ack_ff <= 1'b0;
      avs_waitrequest <= 1'b1;
      rdata_ff <= '0;
      ctrl_ff <= CTRL_RST;
    end else if (clk_en) begin
      ack_ff <= (avs_read || avs_write) && !ack_ff;
      avs_waitrequest <= !((avs_read || avs_write) && !ack_ff);
      if (wr_sel && (avs_address == ADDR_CTRL[4:0])) begin
        for (int i = 0; i < 4; i++) begin
          if (avs_byteenable[i]) begin
            ctrl_ff[i*8 +: 8] <= avs_writedata[i*8 +: 8];
          end
        end
      end
      if (rd_sel) begin
        case (avs_address)
          ADDR_CTRL[4:0]: rdata_ff <= ctrl_ff;
          ADDR_STATUS[4:0]: rdata_ff <= status_word;
          ADDR_RATE[4:0]: rdata_ff <= 32'(rate_ff);
          ADDR_OFFSET[4:0]: rdata_ff <= 32'(off_ff);
          ADDR_COUNT[4:0]: rdata_ff <= {19'h0, su_ff, 3'h0, even_cnt};
          default: rdata_ff <= '0;
        endcase
      end
    end
  end
  assign avs_readdata = rdata_ff;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      poc_state <= TCS_POC_STARTUP;
      rate_corr <= '0;
      offset_corr <= '0;
      startup_nodes <= '0;
    end else if (clk_en) begin
      poc_state <= poc_ff;
      rate_corr <= rate_ff;
      offset_corr <= off_ff;
      startup_nodes <= su_ff;
    end
  end
endmodule
`default_nettype wire

// file: design/tcs_pkg.sv
package tcs_pkg;
  localparam int ID_W = 11;
  localparam int DEV_W = 16;
  localparam int RC_W = 12;
  localparam int NODE_W = 5;
  localparam int SYNC_NODE_MAX_DEF = 15;
  localparam logic [ID_W-1:0] STATIC_SLOT_ID_MAX = 11'h3FF;
  localparam int WUS_PER_PATTERN = 2;
  localparam int INIT_RATE_DELAY_CYCLES = 3;
  localparam logic [31:0] ADDR_CTRL = 32'h0000_0000;
  localparam logic [31:0] ADDR_STATUS = 32'h0000_0004;
  localparam logic [31:0] ADDR_RATE = 32'h0000_0008;
  localparam logic [31:0] ADDR_OFFSET = 32'h0000_000C;
  localparam logic [31:0] ADDR_COUNT = 32'h0000_0010;
  localparam int CTRL_HALT_BIT = 0;
  localparam int CTRL_MAXNODE_LSB = 8;
  localparam int CTRL_INITOFF_LSB = 16;
  localparam int ST_MRC = 0;
  localparam int ST_CCF = 1;
  localparam int ST_SFO = 2;
  localparam int ST_WUPA = 3;
  localparam int ST_WUPB = 4;
  localparam int ST_POC_LSB = 8;
  localparam logic [31:0] CTRL_RST = 32'h0000_0F00;
  typedef enum logic [1:0] {
    TCS_POC_NORMAL_ACTIVE = 2'b00,
    TCS_POC_NORMAL_PASSIVE = 2'b01,
    TCS_POC_HALT = 2'b10,
    TCS_POC_STARTUP = 2'b11
  } tcs_poc_t;
  typedef enum logic [1:0] {
    TCS_WU_IDLE = 2'b00,
    TCS_WU_ONE = 2'b01,
    TCS_WU_GAP = 2'b10
  } tcs_wu_t;
endpackage

// file: design/tcs_wakeup_det.sv
`timescale 1ns/10ps
`default_nettype none
module tcs_wakeup_det (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic wus_pulse,
  input wire logic idle_ok,
  output logic pattern_pulse
);
  import tcs_pkg::*;
  tcs_wu_t state_ff;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_ff <= TCS_WU_IDLE;
      pattern_pulse <= 1'b0;
    end else if (clk_en) begin
      pattern_pulse <= 1'b0;
      case (state_ff)
        TCS_WU_IDLE: begin
          if (wus_pulse) begin
            state_ff <= TCS_WU_GAP;
          end
        end
        TCS_WU_GAP: begin
          if (idle_ok) begin
            state_ff <= TCS_WU_ONE;
          end
        end
        TCS_WU_ONE: begin
          if (wus_pulse) begin
            pattern_pulse <= 1'b1;
            state_ff <= TCS_WU_IDLE;
          end
        end
        default: begin
          state_ff <= TCS_WU_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// file: design/tcs_sync_table.sv
`timescale 1ns/10ps
`default_nettype none
module tcs_sync_table #(
  parameter int DEPTH = tcs_pkg::SYNC_NODE_MAX_DEF
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic clear,
  input wire logic store,
  input wire logic [tcs_pkg::ID_W-1:0] id_in,
  input wire logic [tcs_pkg::DEV_W-1:0] dev_in,
  output logic hit,
  output logic [tcs_pkg::DEV_W-1:0] hit_dev,
  output logic [tcs_pkg::NODE_W-1:0] count
);
  import tcs_pkg::*;
  logic [ID_W-1:0] id_mem [DEPTH];
  logic [DEV_W-1:0] dev_mem [DEPTH];
  logic [DEPTH-1:0] vld_ff;
  logic [DEPTH-1:0] match;
  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : gen_ent
      assign match[g] = vld_ff[g] && (id_mem[g] == id_in);
      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          vld_ff[g] <= 1'b0;
          id_mem[g] <= '0;
          dev_mem[g] <= '0;
        end else if (clk_en) begin
          if (clear) begin
            vld_ff[g] <= 1'b0;
          end else if (store && (count == NODE_W'(g))) begin
            vld_ff[g] <= 1'b1;
            id_mem[g] <= id_in;
            dev_mem[g] <= dev_in;
          end
        end
      end
    end
  endgenerate
  always_comb begin
    hit = |match;
    hit_dev = '0;
    for (int i = 0; i < DEPTH; i++) begin
      if (match[i]) begin
        hit_dev = dev_mem[i];
      end
    end
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      count <= '0;
    end else if (clk_en) begin
      if (clear) begin
        count <= '0;
      end else if (store && (count < NODE_W'(DEPTH))) begin
        count <= count + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// file: test/tcs_clock_sync_properties.sv
`timescale 1ns/10ps
`default_nettype none
module tcs_clock_sync_properties (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic frame_valid,
  input wire logic cycle_end,
  input wire logic integrating,
  input wire logic [1:0] poc_state,
  input wire logic [tcs_pkg::RC_W-1:0] rate_corr,
  input wire logic [tcs_pkg::DEV_W-1:0] offset_corr,
  input wire logic [tcs_pkg::NODE_W-1:0] startup_nodes
);
  import tcs_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  property p_ack_cause;
    $fell(avs_waitrequest) |-> $past(avs_read || avs_write);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("answer without request");
  property p_ack_one;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("bus answer not one cycle");
  property p_unmapped;
    avs_read && !avs_waitrequest && avs_address > 5'h10 |-> avs_readdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_poc_mirror;
    avs_read && !avs_waitrequest && avs_address == 5'h04 |-> avs_readdata[9:8] == poc_state;
  endproperty
  a_poc_mirror: assert property (p_poc_mirror) else $error("state field mismatch");
  property p_poc_cause;
    $changed(poc_state) |-> $past(cycle_end) || $past(cycle_end, 2);
  endproperty
  a_poc_cause: assert property (p_poc_cause) else $error("state moved off cycle end");
  property p_halt_keep;
    $past(poc_state) == TCS_POC_HALT |-> poc_state == TCS_POC_HALT;
  endproperty
  a_halt_keep: assert property (p_halt_keep) else $error("halt left without reset");
  property p_corr_cause;
    $changed(rate_corr) || $changed(offset_corr) |-> $past(cycle_end) || $past(cycle_end, 2)
      || $past(avs_write) || $past(avs_write, 2) || $past(integrating, 2);
  endproperty
  a_corr_cause: assert property (p_corr_cause) else $error("correction moved freely");
  property p_start_cause;
    $changed(startup_nodes) |-> $past(frame_valid) || $past(frame_valid, 2)
      || $past(cycle_end) || $past(cycle_end, 2);
  endproperty
  a_start_cause: assert property (p_start_cause) else $error("start count moved freely");
  property p_start_max;
    startup_nodes <= 5'h0F;
  endproperty
  a_start_max: assert property (p_start_max) else $error("start count above limit");
endmodule
bind tcs_clock_sync tcs_clock_sync_properties u_chk (.sys_clk(sys_clk), .rst(rst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .frame_valid(frame_valid), .cycle_end(cycle_end), .integrating(integrating),
  .poc_state(poc_state),
  .rate_corr(rate_corr), .offset_corr(offset_corr), .startup_nodes(startup_nodes));
`default_nettype wire

// file: test/tcs_nodes_model.sv
`timescale 1ns/10ps
`default_nettype none
module tcs_nodes_model (
  input wire logic sys_clk,
  output logic frame_valid,
  output logic frame_sync,
  output logic frame_startup,
  output logic [tcs_pkg::ID_W-1:0] frame_id,
  output logic [tcs_pkg::DEV_W-1:0] frame_dev,
  output logic strp_at_ap,
  output logic cycle_end,
  output logic cycle_odd,
  output logic [1:0] wus,
  output logic [1:0] idle
);
  import tcs_pkg::*;
  initial begin
    {frame_valid, frame_sync, frame_startup, strp_at_ap, cycle_end, cycle_odd} = 6'h00;
    frame_id = 11'h000;
    frame_dev = 16'h0000;
    wus = 2'h0;
    idle = 2'h0;
  end
  task frame(input logic [ID_W-1:0] id, input logic [DEV_W-1:0] dev, input logic s,
      input logic su);
    @(posedge sys_clk);
    frame_valid <= 1'b1;
    frame_sync <= s;
    frame_startup <= su;
    frame_id <= id;
    frame_dev <= dev;
    strp_at_ap <= s;
    @(posedge sys_clk);
    frame_valid <= 1'b0;
    frame_sync <= 1'b0;
    frame_startup <= 1'b0;
    strp_at_ap <= 1'b0;
    // stale id would hide a missing qualifier
    frame_id <= ~id;
    frame_dev <= ~dev;
  endtask
  task wake(input logic ch, input logic gap);
    if (gap) begin
      @(posedge sys_clk);
      idle[ch] <= 1'b1;
      @(posedge sys_clk);
      idle[ch] <= 1'b0;
    end
    @(posedge sys_clk);
    wus[ch] <= 1'b1;
    @(posedge sys_clk);
    wus[ch] <= 1'b0;
  endtask
  task start(input logic odd);
    @(posedge sys_clk);
    cycle_odd <= odd;
  endtask
  task fin;
    @(posedge sys_clk);
    cycle_end <= 1'b1;
    @(posedge sys_clk);
    cycle_end <= 1'b0;
    repeat (3) @(posedge sys_clk);
  endtask
endmodule
`default_nettype wire

// file: test/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import tcs_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic dyn_slot_max = 1'b0;
  logic integrating = 1'b0;
  logic clk_en = 1'b1;
  wire [31:0] avs_readdata;
  wire avs_waitrequest, frame_valid, frame_sync, frame_startup, strp_at_ap, cycle_end, cycle_odd;
  wire [ID_W-1:0] frame_id;
  wire [DEV_W-1:0] frame_dev, offset_corr;
  wire [1:0] wus, idle, poc_state;
  wire [RC_W-1:0] rate_corr;
  wire [NODE_W-1:0] startup_nodes;
  int fail_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  logic [31:0] q;
  logic [RC_W-1:0] r0;
  always #25 sys_clk = ~sys_clk;
  tcs_clock_sync i_tcs_clock_sync (.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .frame_valid(frame_valid), .frame_sync(frame_sync),
    .frame_startup(frame_startup), .frame_id(frame_id), .frame_dev(frame_dev),
    .strp_at_ap(strp_at_ap), .cycle_end(cycle_end), .cycle_odd(cycle_odd),
    .integrating(integrating), .dyn_slot_max(dyn_slot_max), .wus_a(wus[0]), .wus_b(wus[1]),
    .idle_a(idle[0]), .idle_b(idle[1]), .poc_state(poc_state), .rate_corr(rate_corr),
    .offset_corr(offset_corr), .startup_nodes(startup_nodes));
  tcs_nodes_model u_nodes (.sys_clk(sys_clk), .frame_valid(frame_valid),
    .frame_sync(frame_sync), .frame_startup(frame_startup), .frame_id(frame_id),
    .frame_dev(frame_dev), .strp_at_ap(strp_at_ap), .cycle_end(cycle_end),
    .cycle_odd(cycle_odd), .wus(wus), .idle(idle));
  task print_verdict;
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // request held until waitrequest seen low
  task bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    avs_address <= a[4:0];
    avs_read <= ~wr;
    avs_write <= wr;
    avs_writedata <= d;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task do_reset;
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
  endtask
  task dbl(input logic odd_hit, input logic [ID_W-1:0] id);
    u_nodes.start(1'b0);
    u_nodes.frame(id, 16'h0040, 1'b1, 1'b1);
    u_nodes.frame(id, 16'h0012, 1'b0, 1'b0);
    u_nodes.fin();
    u_nodes.start(1'b1);
    if (odd_hit) begin
      u_nodes.frame(id, 16'h0044, 1'b1, 1'b1);
    end
    u_nodes.fin();
  endtask
  task s_reset;
    bus(1'b0, ADDR_CTRL, 32'h0);
    chk(q, CTRL_RST);
    bus(1'b0, ADDR_STATUS, 32'h0);
    chk(q, 32'h0000_0300);
    bus(1'b0, 32'h0000_0014, 32'h0);
    chk(q, 32'h0);
  endtask
  task s_pair;
    bus(1'b1, ADDR_CTRL, 32'h0001_0F00);
    dbl(1'b1, 11'h005);
    bus(1'b0, ADDR_STATUS, 32'h0);
    chk(q, 32'h0);
    chk({30'h0, poc_state}, {30'h0, TCS_POC_NORMAL_ACTIVE});
    chk({31'h0, offset_corr != 16'h0000}, 32'h1);
  endtask
  task s_missing;
    r0 = rate_corr;
    chk({31'h0, r0 != '0}, 32'h1);
    dbl(1'b0, 11'h007);
    bus(1'b0, ADDR_STATUS, 32'h0);
    chk(q, 32'h0000_0103);
    chk({20'h0, rate_corr}, {20'h0, r0});
    repeat (10) @(posedge sys_clk);
    bus(1'b0, ADDR_STATUS, 32'h0);
    chk(q, 32'h0000_0103);
    bus(1'b1, ADDR_STATUS, 32'h3);
    bus(1'b0, ADDR_STATUS, 32'h0);
    chk(q, 32'h0000_0100);
  endtask
  task s_halt;
    do_reset();
    bus(1'b1, ADDR_CTRL, 32'h0001_0F01);
    dbl(1'b1, 11'h005);
    dbl(1'b0, 11'h005);
    chk({30'h0, poc_state}, {30'h0, TCS_POC_HALT});
  endtask
  task s_overflow;
    do_reset();
    bus(1'b1, ADDR_CTRL, 32'h0001_0200);
    dyn_slot_max <= 1'b1;
    dbl(1'b1, 11'h001);
    bus(1'b0, ADDR_STATUS, 32'h0);
    chk(q, 32'h0);
    u_nodes.start(1'b0);
    for (int i = 1; i <= 3; i++) begin
      u_nodes.frame(i[ID_W-1:0], 16'h0020, 1'b1, 1'b1);
      if (i == 2) begin
        bus(1'b0, ADDR_STATUS, 32'h0);
        chk(q & 32'h4, 32'h0);
      end
    end
    bus(1'b0, ADDR_COUNT, 32'h0);
    chk(q, 32'h0000_0202);
    chk({27'h0, startup_nodes}, 32'h2);
    u_nodes.fin();
    bus(1'b0, ADDR_STATUS, 32'h0);
    chk(q, 32'h0000_0004);
    dyn_slot_max <= 1'b0;
  endtask
  // every second symbol, not every one
  task s_wake;
    for (int ch = 0; ch < 2; ch++) begin
      u_nodes.wake(ch[0], 1'b0);
      u_nodes.wake(ch[0], 1'b1);
      bus(1'b0, ADDR_STATUS, 32'h0);
      chk(q & 32'h18, 32'h8 << ch);
      bus(1'b1, ADDR_STATUS, 32'h18);
      u_nodes.wake(ch[0], 1'b1);
      bus(1'b0, ADDR_STATUS, 32'h0);
      chk(q & 32'h18, 32'h0);
      u_nodes.wake(ch[0], 1'b1);
      bus(1'b0, ADDR_STATUS, 32'h0);
      chk(q & 32'h18, 32'h8 << ch);
      bus(1'b1, ADDR_STATUS, 32'h18);
    end
    // frozen engine must not count symbols
    @(posedge sys_clk);
    clk_en <= 1'b0;
    u_nodes.wake(1'b0, 1'b0);
    u_nodes.wake(1'b0, 1'b1);
    clk_en <= 1'b1;
    bus(1'b0, ADDR_STATUS, 32'h0);
    chk(q & 32'h18, 32'h0);
  endtask
  task s_integ;
    do_reset();
    bus(1'b1, ADDR_CTRL, 32'h0001_0F00);
    integrating <= 1'b1;
    repeat (3) @(posedge sys_clk);
    chk({20'h0, rate_corr}, 32'h1);
    dbl(1'b1, 11'h009);
    chk({20'h0, rate_corr}, 32'h1);
    chk({30'h0, poc_state}, {30'h0, TCS_POC_STARTUP});
    dbl(1'b0, 11'h009);
    bus(1'b0, ADDR_STATUS, 32'h0);
    chk(q, 32'h0000_0303);
    integrating <= 1'b0;
  endtask
  // a few hundred cycles expected; generous ceiling
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      fail_count++;
      print_verdict();
    end
  end
  initial begin
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    s_reset();
    s_pair();
    s_missing();
    s_halt();
    s_overflow();
    s_wake();
    s_integ();
    print_verdict();
  end
endmodule
`default_nettype wire
